// ---- common/viterbi_pm_regs.svh ----
// Opcode values, field positions and reset values for the path-metric unit
`ifndef VITERBI_PM_REGS_SVH
`define VITERBI_PM_REGS_SVH
// Function
// (RL1) Low sub/add: minus, plus, plus, minus
// (RL2) Low add/sub: plus, minus, minus, plus
// (RL3) Opcode E5F uses low branch metric, sub/add
// (RL4) High sub/add with store uses high metric
// (RL5) Parallel store writes whole store register
// (RL6) Low add/sub with store computes and stores
// (RL7) Pipeline picks store register five to eight
// (RL8) Pipeline names branch register zero or one
// (RL9) All arithmetic is 16-bit two's complement
// (RL10) No status flag ever changes
// (RL11) Every instruction completes in one cycle
// (RL12) State metrics sit low and high halves
// (RL13) Metrics 0,1 to dest A; 2,3 to B
// (RL14) Second word: store, branch, address byte
// (RL15) Overflow wraps silently modulo 2^16

// ------------------------------------------------------------
// Single-word opcodes, upper twelve bits
// ------------------------------------------------------------
`define OP_LOW_SUB_ADD 12'hE5E
`define OP_LOW_ADD_SUB 12'hE53
`define OP_LOW_SUB_ADD_ALT 12'hE5F
`define OP_HIGH_ADD_SUB 12'hE57
// ------------------------------------------------------------
// Parallel-store opcodes, full first word
// ------------------------------------------------------------
`define OP_PAR_LOW_ADD_SUB 16'hE208
`define OP_PAR_HIGH_ADD_SUB 16'hE209
`define OP_PAR_LOW_SUB_ADD 16'hE20A
`define OP_PAR_HIGH_SUB_ADD 16'hE20B
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SHORT_BM_FIELD_LSB 0
`define PAR_STORE_FIELD_LSB 12
`define PAR_BM_FIELD_LSB 8
`define PAR_ADDR_FIELD_LSB 0
`define STORE_REG_FIRST 4'h5
`define STORE_REG_LAST 4'h8
`define BM_REG_LAST 4'h1
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RESET_WORD 32'h0000_0000
`define RESET_BYTE 8'h00
`endif

// ---- common/viterbi_pm_pkg.sv ----
// Types shared by the path-metric datapath
package viterbi_pm_pkg;
   typedef logic [15:0] metric_t;
   typedef logic [31:0] vreg_t;
   typedef logic [3:0] reg_field_t;
   typedef logic [7:0] addr_byte_t;
endpackage

// ---- design/path_metric_unit.sv ----
// Four-way add/subtract of one branch metric against two state metrics
`timescale 1ns/1ps
module path_metric_unit (
   input wire viterbi_pm_pkg::metric_t sm0,
   input wire viterbi_pm_pkg::metric_t sm1,
   input wire viterbi_pm_pkg::metric_t bm,
   input wire logic sub_first,
   output viterbi_pm_pkg::metric_t pm0,
   output viterbi_pm_pkg::metric_t pm1,
   output viterbi_pm_pkg::metric_t pm2,
   output viterbi_pm_pkg::metric_t pm3
);
   import viterbi_pm_pkg::*;

   // Plain 16-bit sums: carries out are dropped, so results wrap
   wire metric_t s0_plus = sm0 + bm; // [RL9] [RL15]
   wire metric_t s0_minus = sm0 - bm; // [RL9] [RL15]
   wire metric_t s1_plus = sm1 + bm; // [RL9] [RL15]
   wire metric_t s1_minus = sm1 - bm; // [RL9] [RL15]

   assign pm0 = sub_first ? s0_minus : s0_plus; // [RL1] [RL2]
   assign pm1 = sub_first ? s1_plus : s1_minus; // [RL1] [RL2]
   assign pm2 = sub_first ? s0_plus : s0_minus; // [RL1] [RL2]
   assign pm3 = sub_first ? s1_minus : s1_plus; // [RL1] [RL2]
endmodule

// ---- design/viterbi_path_metric_addsub.sv ----
// Viterbi butterfly path-metric datapath with optional parallel store
`timescale 1ns/1ps
`include "viterbi_pm_regs.svh"
module viterbi_path_metric_addsub (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic ISSUE_VALID,
   input wire logic [15:0] OPCODE_LSW,
   input wire logic [15:0] OPCODE_MSW,
   input wire viterbi_pm_pkg::vreg_t STATE_METRIC_REG,
   input wire viterbi_pm_pkg::vreg_t BRANCH_REG_0,
   input wire viterbi_pm_pkg::vreg_t BRANCH_REG_1,
   input wire viterbi_pm_pkg::vreg_t STORE_REG_5,
   input wire viterbi_pm_pkg::vreg_t STORE_REG_6,
   input wire viterbi_pm_pkg::vreg_t STORE_REG_7,
   input wire viterbi_pm_pkg::vreg_t STORE_REG_8,
   output logic DEST_WE,
   output viterbi_pm_pkg::vreg_t PATH_METRIC_DEST_A,
   output viterbi_pm_pkg::vreg_t PATH_METRIC_DEST_B,
   output logic MEM_STORE_WE,
   output viterbi_pm_pkg::addr_byte_t MEM_ADDR_BYTE,
   output viterbi_pm_pkg::vreg_t MEM_STORE_DATA,
   output logic STATUS_WE,
   output logic OPERAND_ERROR
);
   import viterbi_pm_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic metric_t pick_half(input vreg_t word, input logic hi);
      pick_half = hi ? word[31:16] : word[15:0];
   endfunction

   function automatic logic in_range(input reg_field_t f,
                                     input reg_field_t lo,
                                     input reg_field_t hi);
      in_range = (f >= lo) && (f <= hi);
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire [11:0] op_top = OPCODE_LSW[15:4];
   wire is_lsa = (op_top == `OP_LOW_SUB_ADD); // [RL1]
   wire is_las = (op_top == `OP_LOW_ADD_SUB); // [RL2]
   wire is_lsa_alt = (op_top == `OP_LOW_SUB_ADD_ALT); // [RL3]
   wire is_has = (op_top == `OP_HIGH_ADD_SUB);
   wire is_p_las = (OPCODE_LSW == `OP_PAR_LOW_ADD_SUB); // [RL6]
   wire is_p_has = (OPCODE_LSW == `OP_PAR_HIGH_ADD_SUB);
   wire is_p_lsa = (OPCODE_LSW == `OP_PAR_LOW_SUB_ADD);
   wire is_p_hsa = (OPCODE_LSW == `OP_PAR_HIGH_SUB_ADD); // [RL4]
   wire is_short = is_lsa | is_las | is_lsa_alt | is_has;
   wire is_par = is_p_las | is_p_has | is_p_lsa | is_p_hsa;
   wire sub_first = is_lsa | is_lsa_alt | is_p_lsa | is_p_hsa;
   // Only the high forms take the upper half of the branch register
   wire use_high = is_has | is_p_has | is_p_hsa; // [RL3] [RL4]

   // Second word: store field, branch field, address byte
   wire reg_field_t store_field =
      OPCODE_MSW[`PAR_STORE_FIELD_LSB +: 4]; // [RL14]
   wire reg_field_t bm_field = is_par ?
      OPCODE_MSW[`PAR_BM_FIELD_LSB +: 4] : // [RL14]
      OPCODE_LSW[`SHORT_BM_FIELD_LSB +: 4];
   wire addr_byte_t addr_field =
      OPCODE_MSW[`PAR_ADDR_FIELD_LSB +: 8]; // [RL14]

   // A bad field is refused rather than read from a wrong register
   wire bm_ok = in_range(bm_field, 4'h0, `BM_REG_LAST); // [RL8]
   wire st_ok = in_range(store_field, `STORE_REG_FIRST,
                         `STORE_REG_LAST); // [RL7]
   wire known = ISSUE_VALID & (is_short | is_par);
   wire fields_ok = bm_ok & (~is_par | st_ok);
   wire exec = known & fields_ok;
   wire do_store = exec & is_par; // [RL5]
   wire bad_fields = known & ~fields_ok;

   // ------------------------------------------------------------
   // Operand selection
   // ------------------------------------------------------------
   wire vreg_t bm_reg = bm_field[0] ? BRANCH_REG_1 : BRANCH_REG_0;
   wire metric_t bm = pick_half(bm_reg, use_high);
   wire metric_t sm0 = pick_half(STATE_METRIC_REG, 1'b0); // [RL12]
   wire metric_t sm1 = pick_half(STATE_METRIC_REG, 1'b1); // [RL12]
   wire [1:0] store_idx = 2'(store_field - `STORE_REG_FIRST);
   wire vreg_t store_word =
      (store_idx == 2'h0) ? STORE_REG_5 :
      (store_idx == 2'h1) ? STORE_REG_6 :
      (store_idx == 2'h2) ? STORE_REG_7 : STORE_REG_8; // [RL5]

   metric_t pm0;
   metric_t pm1;
   metric_t pm2;
   metric_t pm3;
   path_metric_unit u_pm (
      .sm0(sm0),
      .sm1(sm1),
      .bm(bm),
      .sub_first(sub_first),
      .pm0(pm0),
      .pm1(pm1),
      .pm2(pm2),
      .pm3(pm3)
   );

   // ------------------------------------------------------------
   // Result registers
   // ------------------------------------------------------------
   // Results land on the edge that takes the instruction, so the
   // next instruction already sees them
   wire vreg_t dest_a_d = {pm1, pm0}; // [RL13]
   wire vreg_t dest_b_d = {pm3, pm2}; // [RL13]

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         DEST_WE <= 1'b0;
         PATH_METRIC_DEST_A <= `RESET_WORD;
         PATH_METRIC_DEST_B <= `RESET_WORD;
      end else begin
         DEST_WE <= exec; // [RL11]
         if (exec) begin
            PATH_METRIC_DEST_A <= dest_a_d; // [RL11]
            PATH_METRIC_DEST_B <= dest_b_d;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         MEM_STORE_WE <= 1'b0;
         MEM_ADDR_BYTE <= `RESET_BYTE;
         MEM_STORE_DATA <= `RESET_WORD;
      end else begin
         MEM_STORE_WE <= do_store; // [RL5] [RL11]
         if (do_store) begin
            MEM_ADDR_BYTE <= addr_field;
            MEM_STORE_DATA <= store_word; // [RL5]
         end
      end
   end

   // Status is never written, not even on a wrapped result
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         STATUS_WE <= 1'b0;
         OPERAND_ERROR <= 1'b0;
      end else begin
         STATUS_WE <= 1'b0; // [RL10] [RL15]
         OPERAND_ERROR <= bad_fields;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   lsa_metrics_a: assert property ( // [RL1]
      @(posedge SYS_CLK) disable iff (!rst_n)
      exec && is_lsa |=> PATH_METRIC_DEST_A ==
         {16'($past(sm1) + $past(bm)), 16'($past(sm0) - $past(bm))})
      else $error("low sub/add dest A wrong");

   las_metrics_a: assert property ( // [RL2]
      @(posedge SYS_CLK) disable iff (!rst_n)
      exec && (is_las || is_p_las) |=> PATH_METRIC_DEST_B ==
         {16'($past(sm1) + $past(bm)), 16'($past(sm0) - $past(bm))})
      else $error("low add/sub dest B wrong");

   alt_low_half_a: assert property ( // [RL3]
      @(posedge SYS_CLK) disable iff (!rst_n)
      exec && is_lsa_alt |-> bm == bm_reg[15:0] && sub_first)
      else $error("alternate low opcode uses wrong metric");

   high_store_a: assert property ( // [RL4]
      @(posedge SYS_CLK) disable iff (!rst_n)
      exec && is_p_hsa |=> PATH_METRIC_DEST_A[15:0] ==
         16'($past(STATE_METRIC_REG[15:0]) - $past(bm_reg[31:16]))
         && MEM_STORE_WE)
      else $error("high sub/add with store wrong");

   store_data_a: assert property ( // [RL5]
      @(posedge SYS_CLK) disable iff (!rst_n)
      MEM_STORE_WE |-> $past(do_store) &&
         MEM_STORE_DATA == $past(store_word) &&
         MEM_ADDR_BYTE == $past(OPCODE_MSW[7:0]))
      else $error("parallel store data or address wrong");

   single_cycle_a: assert property ( // [RL11]
      @(posedge SYS_CLK) disable iff (!rst_n)
      $rose(ISSUE_VALID && exec) |=> DEST_WE ##1
         (DEST_WE == $past(exec)))
      else $error("result not written in one cycle");

   no_status_a: assert property ( // [RL10]
      @(posedge SYS_CLK) disable iff (!rst_n)
      exec |=> !STATUS_WE)
      else $error("status written by path metric op");

   dest_halves_a: assert property ( // [RL13]
      @(posedge SYS_CLK) disable iff (!rst_n)
      exec |=> PATH_METRIC_DEST_A[31:16] == $past(pm1) &&
         PATH_METRIC_DEST_B[15:0] == $past(pm2))
      else $error("path metrics in wrong halves");

   bad_field_a: assert property ( // [RL7] [RL8]
      @(posedge SYS_CLK) disable iff (!rst_n)
      bad_fields |=> OPERAND_ERROR && !DEST_WE && !MEM_STORE_WE)
      else $error("bad register field not refused");
endmodule

// ---- verif/issue_pipeline_model.sv ----
// Model of the issuing pipeline: operand registers and instruction words
`timescale 1ns/1ps
module issue_pipeline_model (
   input wire logic clk,
   output logic issue_valid,
   output logic [15:0] lsw,
   output logic [15:0] msw,
   output viterbi_pm_pkg::vreg_t sm_reg,
   output viterbi_pm_pkg::vreg_t bm_reg_0,
   output viterbi_pm_pkg::vreg_t bm_reg_1,
   output viterbi_pm_pkg::vreg_t st_reg_5,
   output viterbi_pm_pkg::vreg_t st_reg_6,
   output viterbi_pm_pkg::vreg_t st_reg_7,
   output viterbi_pm_pkg::vreg_t st_reg_8
);
   import viterbi_pm_pkg::*;
   // ------------------------------------------------------------
   // Operands
   // ------------------------------------------------------------
   initial begin
      issue_valid = 1'b0;
      lsw = 16'h0000;
      msw = 16'h0000;
      sm_reg = 32'h8005_7FF0; // Metric 0 low, metric 1 high
      bm_reg_0 = 32'hFFE0_0020;
      bm_reg_1 = 32'h1234_8000;
      st_reg_5 = 32'hA5A5_0005;
      st_reg_6 = 32'h5A5A_0006;
      st_reg_7 = 32'hC3C3_0007;
      st_reg_8 = 32'h3C3C_0008;
   end
   // ------------------------------------------------------------
   // Issue
   // ------------------------------------------------------------
   // Callers other than test_refuse keep branch field 0..1, and store field 5..8 on parallel-store ops
   task automatic issue(input logic [15:0] l, input logic [15:0] m);
      @(posedge clk);
      issue_valid <= 1'b1;
      lsw <= l;
      msw <= m;
   endtask
   // Idle words toggle so a stale word is never mistaken for a live one
   task automatic idle();
      @(posedge clk);
      issue_valid <= 1'b0;
      lsw <= ~lsw;
      msw <= ~msw;
   endtask
endmodule

// ---- verif/test_viterbi_path_metric_addsub.sv ----
// Self-checking bench for the Viterbi path-metric datapath
`timescale 1ns/1ps
module test_viterbi_path_metric_addsub;
   import viterbi_pm_pkg::*;
   logic sys_clk;
   logic rst_n;
   logic issue_valid;
   logic [15:0] lsw;
   logic [15:0] msw;
   vreg_t sm_reg, bm_reg_0, bm_reg_1, st_reg_5, st_reg_6, st_reg_7, st_reg_8;
   logic dest_we, mem_we, status_we, op_err;
   vreg_t dest_a, dest_b, mem_data;
   addr_byte_t mem_addr;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;

   issue_pipeline_model pipe (.clk(sys_clk), .issue_valid(issue_valid),
      .lsw(lsw), .msw(msw), .sm_reg(sm_reg), .bm_reg_0(bm_reg_0),
      .bm_reg_1(bm_reg_1), .st_reg_5(st_reg_5), .st_reg_6(st_reg_6),
      .st_reg_7(st_reg_7), .st_reg_8(st_reg_8));
   viterbi_path_metric_addsub dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
      .ISSUE_VALID(issue_valid), .OPCODE_LSW(lsw), .OPCODE_MSW(msw),
      .STATE_METRIC_REG(sm_reg), .BRANCH_REG_0(bm_reg_0),
      .BRANCH_REG_1(bm_reg_1), .STORE_REG_5(st_reg_5),
      .STORE_REG_6(st_reg_6), .STORE_REG_7(st_reg_7),
      .STORE_REG_8(st_reg_8), .DEST_WE(dest_we),
      .PATH_METRIC_DEST_A(dest_a), .PATH_METRIC_DEST_B(dest_b),
      .MEM_STORE_WE(mem_we), .MEM_ADDR_BYTE(mem_addr),
      .MEM_STORE_DATA(mem_data), .STATUS_WE(status_we),
      .OPERAND_ERROR(op_err));
   // ------------------------------------------------------------
   // Clock, timeout and checking
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // About 51 cycles are needed; the ceiling leaves wide margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 1000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic check(input string what, input logic [111:0] seen,
                        input logic [111:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Expected results from the opcode and the live operands
   task automatic expect_op(input logic [15:0] l, input logic [15:0] m);
      logic par;
      logic sub;
      vreg_t bm;
      metric_t d;
      vreg_t sv [4];
      par = l[15:4] == 12'hE20;
      sub = par ? l[1] : l[7:5] == 3'b111;
      bm = (par ? m[8] : l[0]) ? bm_reg_1 : bm_reg_0;
      d = (par ? l[0] : l[7:4] == 4'h7) ? bm[31:16] : bm[15:0];
      d = sub ? d : -d; // Wraps, never saturates
      sv = '{st_reg_5, st_reg_6, st_reg_7, st_reg_8};
      check("dest_we", dest_we, 1'b1);
      check("dest_a", dest_a, {sm_reg[31:16] + d, sm_reg[15:0] - d});
      check("dest_b", dest_b, {sm_reg[31:16] - d, sm_reg[15:0] + d});
      check("store_we", mem_we, par);
      if (par) begin
         check("store", {mem_addr, mem_data},
               {m[7:0], sv[2'(m[13:12] - 2'd1)]});
      end
      check("status_we", status_we, 1'b0);
      check("op_err", op_err, 1'b0);
   endtask
   task automatic run_op(input logic [15:0] l, input logic [15:0] m);
      pipe.issue(l, m);
      pipe.idle();
      #1;
      expect_op(l, m);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_short();
      logic [11:0] ops [4];
      ops = '{12'hE5E, 12'hE53, 12'hE5F, 12'hE57};
      for (int i = 0; i < 8; i++) begin
         run_op({ops[i / 2], 4'(i % 2)}, 16'hFFFF);
      end
      $display("test_short done");
   endtask
   task automatic test_store();
      for (int i = 0; i < 4; i++) begin
         run_op(16'hE208 + 16'(i),
                {4'(i + 5), 4'(i % 2), 8'(8'h3C + i)});
      end
      $display("test_store done");
   endtask
   task automatic test_b2b();
      pipe.issue(16'hE531, 16'h0000);
      pipe.issue(16'hE20B, 16'h80C3);
      #1;
      expect_op(16'hE531, 16'h0000);
      pipe.issue(16'hE5E0, 16'h0000);
      #1;
      expect_op(16'hE20B, 16'h80C3);
      pipe.idle();
      #1;
      expect_op(16'hE5E0, 16'h0000);
      $display("test_b2b done");
   endtask
   // Held values are those of the last op above, worked out by hand
   task automatic test_refuse();
      logic [31:0] bad [4];
      bad = '{32'hE5E2_0000, 32'hE20A_4000, 32'hE208_5200, 32'h1234_5100};
      for (int i = 0; i < 4; i++) begin
         pipe.issue(bad[i][31:16], bad[i][15:0]);
         pipe.idle();
         #1;
         check("refused", {dest_we, mem_we, op_err, status_we, dest_a, dest_b},
               {2'b00, i != 3, 1'b0, 32'h8025_7FD0, 32'h7FE5_8010});
      end
      $display("test_refuse done");
   endtask
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      repeat (11) @(posedge sys_clk);
      #1;
      check("reset", {dest_we, mem_we, status_we, op_err, dest_a, dest_b,
                      mem_addr, mem_data}, '0);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      test_short();
      test_store();
      test_b2b();
      test_refuse();
      end_sim();
   end
endmodule
